// ---- hw/gpc_params.svh ----
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// ----------------------------------------
// Pin count and reset values
// ----------------------------------------
`define GPC_NPIN 32
`define GPC_RST_VAL 32'h0000_0000
`define GPC_OE_N_RST 32'hffff_ffff

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPC_OFF_LEVEL 7'h00
`define GPC_OFF_SENSE 7'h04
`define GPC_OFF_DRVEN 7'h08
`define GPC_OFF_DRVLVL 7'h0c
`define GPC_OFF_PULLUP 7'h10
`define GPC_OFF_STRENGTH 7'h14
`define GPC_OFF_RISE_EN 7'h18
`define GPC_OFF_RISE_PEND 7'h1c
`define GPC_OFF_FALL_EN 7'h20
`define GPC_OFF_FALL_PEND 7'h24
`define GPC_OFF_ONE_EN 7'h28
`define GPC_OFF_ONE_PEND 7'h2c
`define GPC_OFF_ZERO_EN 7'h30
`define GPC_OFF_ZERO_PEND 7'h34
`define GPC_OFF_FN_EN 7'h38
`define GPC_OFF_FN_SEL 7'h3c
`define GPC_OFF_INVERT 7'h40
`define GPC_OFF_BYP_ONE 7'h44
`define GPC_OFF_BYP_ZERO 7'h48
`define GPC_LAST_INDEX 5'd18

// ----------------------------------------
// Bit positions in a hardware function's control mask
// ----------------------------------------
`define GPC_CTL_VAL 0
`define GPC_CTL_DRV 1
`define GPC_CTL_PULL 2
`define GPC_CTL_STR 3
`define GPC_CTL_IE 4

`endif

// ---- hw/gpc_pkg.sv ----
`include "gpc_params.svh"

package gpc_pkg;

  typedef logic [`GPC_NPIN-1:0] gpc_vec_type;

  // Pad controls as offered by one hardware function; drv is active high.
  typedef struct packed {
    gpc_vec_type val;
    gpc_vec_type drv;
    gpc_vec_type pull;
    gpc_vec_type str;
    gpc_vec_type ie;
  } gpc_pad_type;

endpackage : gpc_pkg

// ---- hw/gpc_top.sv ----
`timescale 1ns/1ps
`include "gpc_params.svh"

// Functional notes
// - Every register holds one bit per pin; there are 32 pins.
// - Sense, drive and pull-up enables reset asynchronously; the rest synchronously, to zero.
// - Each pin is input, output or both via sense and drive enables.
// - Drive level register stores writes regardless of direction; reads return it.
// - Pin level read returns pad level ANDed with sense enable.
// - One separate interrupt output per pin.
// - Rise, fall or level interrupts, each individually enabled per pin.
// - Pad inputs pass a synchronizer before interrupt detection.
// - Interrupt asserts while an enabled rise or fall pending bit is set.
// - Pending bits stay set until software writes one there.
// - Interrupt outputs suit either an interrupt controller or local inputs.
// - After reset all drivers are off and all pull-ups are off.
// - Pull-up follows the pull-up enable register.
// - Pad drive strength follows the drive strength register.
// - Outgoing value is XORed with the invert mask, software or hardware sourced.
// - Up to two hardware functions per pin, enabled and selected by registers.
// - A hardware function drives a fixed subset of pad controls.
// - A missing function leaves the pin under full software control.

module gpc_top
  import gpc_pkg::*;
#(
  parameter gpc_vec_type FN0_PRESENT = 32'hffff_ffff,
  parameter gpc_vec_type FN1_PRESENT = 32'hffff_ffff,
  parameter logic [4:0] FN0_CTL = 5'h1f,
  parameter logic [4:0] FN1_CTL = 5'h1f
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Pads
  input wire gpc_vec_type pad_in,
  output gpc_vec_type pad_out,
  output gpc_vec_type pad_oe_n,
  output gpc_vec_type pad_pull,
  output gpc_vec_type pad_strength,
  output gpc_vec_type pad_ie,
  // Hardware functions
  input wire gpc_pad_type fn0_ctl,
  input wire gpc_pad_type fn1_ctl,
  output gpc_vec_type fn_in,
  // Per-pin interrupts
  output gpc_vec_type irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic en, input logic [6:0] a, input logic [6:0] off);
    return en && (a == off);
  endfunction : hit

  function automatic gpc_vec_type pick(input gpc_vec_type sw, input gpc_vec_type h0,
                                       input gpc_vec_type h1, input gpc_vec_type m0,
                                       input gpc_vec_type m1);
    return (sw & ~(m0 | m1)) | (h0 & m0) | (h1 & m1);
  endfunction : pick

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_r, rd_r, ready_r;
  logic [6:0] wad_r, rad_r;
  logic [31:0] rdata_r;
  wire [31:0] rdata_w;
  gpc_vec_type sense_r, drv_en_r, pullup_r;
  gpc_vec_type level_r, strength_r, rise_en_r, rise_pend_r, fall_en_r, fall_pend_r;
  gpc_vec_type one_en_r, one_pend_r, zero_en_r, zero_pend_r;
  gpc_vec_type fn_en_r, fn_sel_r, invert_r, byp_one_r, byp_zero_r;
  gpc_vec_type sync1_r, sync_r, prev_r, irq_r;
  gpc_vec_type out_r, oe_n_r, pull_r, pds_r, pie_r;

  // Writes use the word address only; a read of a non-word-aligned address returns zero; hsize is not examined.
  wire take_w = hsel && htrans[1] && hready;
  wire wr_take_w = take_w && hwrite;
  wire rd_take_w = take_w && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      ready_r <= 1'b1;
      wad_r <= 7'h00;
      rad_r <= 7'h00;
      rdata_r <= `GPC_RST_VAL;
    end else begin
      wr_r <= wr_take_w;
      rd_r <= rd_take_w;
      ready_r <= !rd_take_w;
      wad_r <= wr_take_w ? {haddr[6:2], 2'b00} : wad_r;
      rad_r <= rd_take_w ? haddr[6:0] : rad_r;
      rdata_r <= rd_r ? rdata_w : rdata_r;
    end
  end

  assign hreadyout = ready_r;
  assign hrdata = rdata_r;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire w_sense = hit(wr_r, wad_r, `GPC_OFF_SENSE);
  wire w_drven = hit(wr_r, wad_r, `GPC_OFF_DRVEN);
  wire w_lvl = hit(wr_r, wad_r, `GPC_OFF_DRVLVL);
  wire w_pull = hit(wr_r, wad_r, `GPC_OFF_PULLUP);
  wire w_str = hit(wr_r, wad_r, `GPC_OFF_STRENGTH);
  wire w_rise_en = hit(wr_r, wad_r, `GPC_OFF_RISE_EN);
  wire w_rise_p = hit(wr_r, wad_r, `GPC_OFF_RISE_PEND);
  wire w_fall_en = hit(wr_r, wad_r, `GPC_OFF_FALL_EN);
  wire w_fall_p = hit(wr_r, wad_r, `GPC_OFF_FALL_PEND);
  wire w_one_en = hit(wr_r, wad_r, `GPC_OFF_ONE_EN);
  wire w_one_p = hit(wr_r, wad_r, `GPC_OFF_ONE_PEND);
  wire w_zero_en = hit(wr_r, wad_r, `GPC_OFF_ZERO_EN);
  wire w_zero_p = hit(wr_r, wad_r, `GPC_OFF_ZERO_PEND);
  wire w_fn_en = hit(wr_r, wad_r, `GPC_OFF_FN_EN);
  wire w_fn_sel = hit(wr_r, wad_r, `GPC_OFF_FN_SEL);
  wire w_inv = hit(wr_r, wad_r, `GPC_OFF_INVERT);
  wire w_byp1 = hit(wr_r, wad_r, `GPC_OFF_BYP_ONE);
  wire w_byp0 = hit(wr_r, wad_r, `GPC_OFF_BYP_ZERO);

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  gpc_vec_type rmap [0:18];
  assign rmap[0] = sync_r & sense_r;
  assign rmap[1] = sense_r;
  assign rmap[2] = drv_en_r;
  assign rmap[3] = level_r;
  assign rmap[4] = pullup_r;
  assign rmap[5] = strength_r;
  assign rmap[6] = rise_en_r;
  assign rmap[7] = rise_pend_r;
  assign rmap[8] = fall_en_r;
  assign rmap[9] = fall_pend_r;
  assign rmap[10] = one_en_r;
  assign rmap[11] = one_pend_r;
  assign rmap[12] = zero_en_r;
  assign rmap[13] = zero_pend_r;
  assign rmap[14] = fn_en_r;
  assign rmap[15] = fn_sel_r;
  assign rmap[16] = invert_r;
  assign rmap[17] = byp_one_r;
  assign rmap[18] = byp_zero_r;
  wire rd_ok_w = (rad_r[6:2] <= `GPC_LAST_INDEX) && (rad_r[1:0] == 2'b00);
  assign rdata_w = rd_ok_w ? rmap[rad_r[6:2]] : 32'h0000_0000;

  // ----------------------------------------
  // Asynchronously reset registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_r <= `GPC_RST_VAL;
      drv_en_r <= `GPC_RST_VAL;
      pullup_r <= `GPC_RST_VAL;
    end else begin
      sense_r <= w_sense ? hwdata : sense_r;
      drv_en_r <= w_drven ? hwdata : drv_en_r;
      pullup_r <= w_pull ? hwdata : pullup_r;
    end
  end

  // ----------------------------------------
  // Synchronously reset registers
  // ----------------------------------------
  always_ff @(posedge hclk) begin
    if (!hresetn) begin
      level_r <= `GPC_RST_VAL;
      strength_r <= `GPC_RST_VAL;
      rise_en_r <= `GPC_RST_VAL;
      fall_en_r <= `GPC_RST_VAL;
      one_en_r <= `GPC_RST_VAL;
      zero_en_r <= `GPC_RST_VAL;
      fn_en_r <= `GPC_RST_VAL;
      fn_sel_r <= `GPC_RST_VAL;
      invert_r <= `GPC_RST_VAL;
      byp_one_r <= `GPC_RST_VAL;
      byp_zero_r <= `GPC_RST_VAL;
    end else begin
      level_r <= w_lvl ? hwdata : level_r;
      strength_r <= w_str ? hwdata : strength_r;
      rise_en_r <= w_rise_en ? hwdata : rise_en_r;
      fall_en_r <= w_fall_en ? hwdata : fall_en_r;
      one_en_r <= w_one_en ? hwdata : one_en_r;
      zero_en_r <= w_zero_en ? hwdata : zero_en_r;
      fn_en_r <= w_fn_en ? hwdata : fn_en_r;
      fn_sel_r <= w_fn_sel ? hwdata : fn_sel_r;
      invert_r <= w_inv ? hwdata : invert_r;
      byp_one_r <= w_byp1 ? hwdata : byp_one_r;
      byp_zero_r <= w_byp0 ? hwdata : byp_zero_r;
    end
  end

  // ----------------------------------------
  // Input synchronizer and event detection
  // ----------------------------------------
  always_ff @(posedge hclk) begin
    if (!hresetn) begin
      sync1_r <= `GPC_RST_VAL;
      sync_r <= `GPC_RST_VAL;
      prev_r <= `GPC_RST_VAL;
    end else begin
      sync1_r <= pad_in;
      sync_r <= sync1_r;
      prev_r <= sync_r;
    end
  end

  wire gpc_vec_type rise_ev_w = ~prev_r & sync_r;
  wire gpc_vec_type fall_ev_w = prev_r & ~sync_r;
  wire gpc_vec_type rise_clr_w = w_rise_p ? hwdata : `GPC_RST_VAL;
  wire gpc_vec_type fall_clr_w = w_fall_p ? hwdata : `GPC_RST_VAL;
  wire gpc_vec_type one_clr_w = w_one_p ? hwdata : `GPC_RST_VAL;
  wire gpc_vec_type zero_clr_w = w_zero_p ? hwdata : `GPC_RST_VAL;
  wire gpc_vec_type rise_keep_w = rise_pend_r & ~rise_clr_w;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge hclk) begin
    if (!hresetn) begin
      rise_pend_r <= `GPC_RST_VAL;
      fall_pend_r <= `GPC_RST_VAL;
      one_pend_r <= `GPC_RST_VAL;
      zero_pend_r <= `GPC_RST_VAL;
    end else begin
      rise_pend_r <= rise_keep_w | rise_ev_w;
      fall_pend_r <= (fall_pend_r & ~fall_clr_w) | fall_ev_w;
      one_pend_r <= (one_pend_r & ~one_clr_w) | sync_r;
      zero_pend_r <= (zero_pend_r & ~zero_clr_w) | ~sync_r;
    end
  end

  wire gpc_vec_type irq_nxt = (rise_pend_r & rise_en_r) | (fall_pend_r & fall_en_r)
                            | (one_pend_r & one_en_r) | (zero_pend_r & zero_en_r)
                            | (sync_r & byp_one_r) | (~sync_r & byp_zero_r);

  // ----------------------------------------
  // Pad control selection
  // ----------------------------------------
  wire gpc_vec_type own0_w = fn_en_r & ~fn_sel_r & FN0_PRESENT;
  wire gpc_vec_type own1_w = fn_en_r & fn_sel_r & FN1_PRESENT;
  wire gpc_vec_type m0_val = own0_w & {`GPC_NPIN{FN0_CTL[`GPC_CTL_VAL]}};
  wire gpc_vec_type m1_val = own1_w & {`GPC_NPIN{FN1_CTL[`GPC_CTL_VAL]}};
  wire gpc_vec_type m0_drv = own0_w & {`GPC_NPIN{FN0_CTL[`GPC_CTL_DRV]}};
  wire gpc_vec_type m1_drv = own1_w & {`GPC_NPIN{FN1_CTL[`GPC_CTL_DRV]}};
  wire gpc_vec_type m0_pull = own0_w & {`GPC_NPIN{FN0_CTL[`GPC_CTL_PULL]}};
  wire gpc_vec_type m1_pull = own1_w & {`GPC_NPIN{FN1_CTL[`GPC_CTL_PULL]}};
  wire gpc_vec_type m0_str = own0_w & {`GPC_NPIN{FN0_CTL[`GPC_CTL_STR]}};
  wire gpc_vec_type m1_str = own1_w & {`GPC_NPIN{FN1_CTL[`GPC_CTL_STR]}};
  wire gpc_vec_type m0_ie = own0_w & {`GPC_NPIN{FN0_CTL[`GPC_CTL_IE]}};
  wire gpc_vec_type m1_ie = own1_w & {`GPC_NPIN{FN1_CTL[`GPC_CTL_IE]}};

  wire gpc_vec_type val_w = pick(level_r, fn0_ctl.val, fn1_ctl.val, m0_val, m1_val) ^ invert_r;
  wire gpc_vec_type drv_w = pick(drv_en_r, fn0_ctl.drv, fn1_ctl.drv, m0_drv, m1_drv);
  wire gpc_vec_type pull_w = pick(pullup_r, fn0_ctl.pull, fn1_ctl.pull, m0_pull, m1_pull);
  wire gpc_vec_type str_w = pick(strength_r, fn0_ctl.str, fn1_ctl.str, m0_str, m1_str);
  wire gpc_vec_type ie_w = pick(sense_r, fn0_ctl.ie, fn1_ctl.ie, m0_ie, m1_ie);
  wire gpc_vec_type sw_out_w = level_r ^ invert_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r <= `GPC_RST_VAL;
      oe_n_r <= `GPC_OE_N_RST;
      pull_r <= `GPC_RST_VAL;
      pds_r <= `GPC_RST_VAL;
      pie_r <= `GPC_RST_VAL;
      irq_r <= `GPC_RST_VAL;
    end else begin
      out_r <= val_w;
      oe_n_r <= ~drv_w;
      pull_r <= pull_w;
      pds_r <= str_w;
      pie_r <= ie_w;
      irq_r <= irq_nxt;
    end
  end

  assign pad_out = out_r;
  assign pad_oe_n = oe_n_r;
  assign pad_pull = pull_r;
  assign pad_strength = pds_r;
  assign pad_ie = pie_r;
  assign fn_in = sync_r;
  // Plain level per pin, usable by any interrupt sink.
  assign irq = irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RESET_IDLE: assert property ($rose(hresetn) |-> pad_oe_n == `GPC_OE_N_RST && pad_pull == 0)
    else $error("pads not idle after reset");
  AST_LEVEL_READ: assert property (rd_r && rad_r == `GPC_OFF_LEVEL
                                   |=> hrdata == $past(rmap[0]) && hreadyout)
    else $error("level readback wrong");
  AST_READ_WAIT: assert property (rd_take_w |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_STORE: assert property (w_lvl |=> level_r == $past(hwdata))
    else $error("drive level not stored");
  AST_HOLD_PEND: assert property (1'b1 |=> (rise_pend_r & $past(rise_keep_w)) == $past(rise_keep_w))
    else $error("pending bit lost");
  AST_RISE_SET: assert property (rise_ev_w != 0 |=> (rise_pend_r & $past(rise_ev_w)) == $past(rise_ev_w))
    else $error("rise event not recorded");
  AST_IRQ_EDGE: assert property ((rise_pend_r & rise_en_r) != 0 |=> irq != 0)
    else $error("enabled rise pending gave no irq");
  AST_IRQ_QUIET: assert property (irq_nxt == 0 |=> irq == 0)
    else $error("irq without enabled cause");
  AST_HIGH_LVL: assert property (sync_r != 0 |=> (one_pend_r & $past(sync_r)) == $past(sync_r))
    else $error("high level not pending");
  AST_SW_DRIVE: assert property (fn_en_r == 0 |=> pad_out == $past(sw_out_w) && pad_oe_n == ~$past(drv_en_r))
    else $error("software drive path wrong");
  AST_FALL_SET: assert property (fall_ev_w != 0 |=> (fall_pend_r & $past(fall_ev_w)) == $past(fall_ev_w))
    else $error("fall event not recorded");
  AST_W1C_CLEAR: assert property (w_rise_p && rise_ev_w == 0 |=> (rise_pend_r & $past(hwdata)) == 0)
    else $error("rise pending not cleared by write of one");
  AST_LOW_LVL: assert property (sync_r != 32'hffff_ffff |=> (zero_pend_r & ~$past(sync_r)) == ~$past(sync_r))
    else $error("low level not pending");

  COV_RISE_IRQ: cover property (rise_ev_w != 0 ##[1:4] irq != 0);
  COV_W1C: cover property (w_rise_p && (rise_pend_r & hwdata) != 0);
  COV_FN_OWN: cover property (own1_w != 0 && fn_en_r != 0);
  COV_READ: cover property (rd_take_w ##2 hreadyout);
  COV_LOW_IRQ: cover property ((zero_pend_r & zero_en_r) != 0 ##1 irq != 0);

endmodule : gpc_top

// ---- sim/gpc_pad_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Board side of the pads
// ----------------------------------------
module gpc_pad_model
  import gpc_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Pad controls from the controller
  input wire gpc_vec_type pad_out,
  input wire gpc_vec_type pad_oe_n,
  input wire gpc_vec_type pad_pull,
  // External board drivers
  input wire gpc_vec_type ext_val,
  input wire gpc_vec_type ext_en,
  // Resolved pad levels
  output gpc_vec_type pad_in
);
  logic tog_r = 1'b0;
  // A floating pin without pull-up shows a level that changes every cycle.
  always_ff @(posedge hclk) begin
    tog_r <= ~tog_r;
  end
  wire gpc_vec_type float_lvl = ({16{2'b01}} ^ {32{tog_r}}) | pad_pull;
  wire gpc_vec_type ext_lvl = (ext_val & ext_en) | (float_lvl & ~ext_en);
  assign pad_in = (pad_out & ~pad_oe_n) | (ext_lvl & pad_oe_n);
endmodule : gpc_pad_model

// ---- sim/tb_gpio_pad_controller.sv ----
`timescale 1ns/1ps

module tb_gpio_pad_controller;
  import gpc_pkg::*;
  localparam gpc_vec_type P1 = 32'h0000_ffff;
  localparam logic [4:0] C1 = 5'h0b;
  localparam logic [6:0] ZOFF[7] = '{7'h18, 7'h20, 7'h28, 7'h30, 7'h44, 7'h48, 7'h08};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  gpc_vec_type pad_in, pad_out, pad_oe_n, pad_pull, pad_strength, pad_ie, fn_in, irq;
  gpc_pad_type fn0 = '0;
  gpc_pad_type fn1 = '0;
  gpc_vec_type ext_val = 32'h0;
  gpc_vec_type ext_en = 32'hffff_ffff;
  logic rd_dp = 1'b0;
  gpc_vec_type q[$];
  gpc_vec_type sw[19];
  int err_total = 0;
  int n_tests = 0;
  int seed = 95807;
  int p;
  gpc_vec_type b;
  gpc_vec_type o0;
  gpc_vec_type o1;

  always #5 hclk = ~hclk;

  gpc_top #(.FN1_PRESENT(P1), .FN1_CTL(C1)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull(pad_pull),
    .pad_strength(pad_strength), .pad_ie(pad_ie), .fn0_ctl(fn0), .fn1_ctl(fn1), .fn_in(fn_in), .irq(irq));

  gpc_pad_model partner (
    .hclk(hclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull(pad_pull),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task cmp_pin(input gpc_vec_type got, input gpc_vec_type exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t pad or irq mismatch got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  task cmp_rd(input logic [31:0] got, input gpc_vec_type exp);
    n_tests++;
    if (got !== exp || hresp !== 1'b0) begin
      err_total++;
      $display("[FAIL] %0t read mismatch got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd

  // Single word transfer; a read queues its expected data for the monitor.
  task xfer(input logic w, input logic [6:0] a, input gpc_vec_type d);
    @(posedge hclk);
    if (!w) q.push_back(d);
    if (w) sw[a[6:2]] = d;
    hsel <= 1'b1;
    haddr <= {25'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_dp <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask : xfer

  task set_ext(input gpc_vec_type v);
    @(posedge hclk);
    ext_val <= v;
    repeat (6) @(posedge hclk);
    #1;
  endtask : set_ext

  function automatic gpc_vec_type mix(gpc_vec_type s, gpc_vec_type f0, gpc_vec_type f1,
                                      gpc_vec_type m0, gpc_vec_type m1);
    return (s & ~m0 & ~m1) | (f0 & m0) | (f1 & m1);
  endfunction : mix

  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) cmp_rd(hrdata, q.pop_front());
  end

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #100us;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Low pins keep the low-level pending bits set; the unmapped word reads zero.
    for (int i = 0; i < 20; i++) xfer(1'b0, 7'(i * 4), (i == 13) ? 32'hffff_ffff : 32'h0);
    cmp_pin(pad_oe_n, 32'hffff_ffff);
    cmp_pin(pad_pull, 32'h0);
    for (int i = 1; i < 19; i++) if (!(i inside {7, 9, 11, 13})) xfer(1'b1, 7'(i * 4), $random(seed));
    xfer(1'b1, 7'h0, $random(seed));
    for (int i = 1; i < 19; i++) if (!(i inside {7, 9, 11, 13})) xfer(1'b0, 7'(i * 4), sw[i]);
    xfer(1'b1, 7'h38, 32'h0);
    ext_en <= ~sw[2];
    ext_val <= $random(seed);
    repeat (3) @(posedge hclk);
    #1;
    cmp_pin(pad_oe_n, ~sw[2]);
    cmp_pin(pad_out, sw[3] ^ sw[16]);
    cmp_pin(pad_pull, sw[4]);
    cmp_pin(pad_strength, sw[5]);
    cmp_pin(pad_ie, sw[1]);
    xfer(1'b0, 7'h0, (((sw[3] ^ sw[16]) & sw[2]) | (ext_val & ~sw[2])) & sw[1]);
    // Edge and level interrupts on one random pin.
    foreach (ZOFF[k]) xfer(1'b1, ZOFF[k], 32'h0);
    ext_en <= 32'hffff_ffff;
    set_ext(32'h0);
    for (int i = 7; i < 12; i += 2) xfer(1'b1, 7'(i * 4), 32'hffff_ffff);
    p = $random(seed) & 31;
    b = 32'h1 << p;
    xfer(1'b1, 7'h18, b);
    xfer(1'b1, 7'h20, b);
    set_ext(b);
    cmp_pin(irq, b);
    cmp_pin(fn_in, b);
    xfer(1'b0, 7'h1c, b);
    xfer(1'b0, 7'h2c, b);
    xfer(1'b1, 7'h1c, 32'h0);
    xfer(1'b0, 7'h1c, b);
    xfer(1'b1, 7'h1c, b);
    repeat (3) @(posedge hclk);
    #1;
    cmp_pin(irq, 32'h0);
    set_ext(32'h0);
    cmp_pin(irq, b);
    xfer(1'b0, 7'h24, b);
    xfer(1'b1, 7'h24, 32'hffff_ffff);
    xfer(1'b1, 7'h18, 32'h0);
    xfer(1'b1, 7'h20, 32'h0);
    xfer(1'b1, 7'h30, b);
    xfer(1'b1, 7'h34, 32'hffff_ffff);
    xfer(1'b0, 7'h34, 32'hffff_ffff);
    repeat (3) @(posedge hclk);
    #1;
    cmp_pin(irq, b);
    xfer(1'b1, 7'h30, 32'h0);
    xfer(1'b1, 7'h44, b);
    set_ext(b);
    cmp_pin(irq, b);
    set_ext(32'h0);
    cmp_pin(irq, 32'h0);
    // Hardware functions take over pad controls.
    for (int k = 0; k < 4; k++) begin
      @(posedge hclk);
      fn0 <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      fn1 <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      xfer(1'b1, 7'h38, $random(seed));
      xfer(1'b1, 7'h3c, $random(seed));
      repeat (3) @(posedge hclk);
      #1;
      o0 = sw[14] & ~sw[15];
      o1 = sw[14] & sw[15] & P1;
      cmp_pin(pad_out, mix(sw[3], fn0.val, fn1.val, o0, C1[0] ? o1 : '0) ^ sw[16]);
      cmp_pin(pad_oe_n, ~mix(sw[2], fn0.drv, fn1.drv, o0, C1[1] ? o1 : '0));
      cmp_pin(pad_pull, mix(sw[4], fn0.pull, fn1.pull, o0, C1[2] ? o1 : '0));
      cmp_pin(pad_strength, mix(sw[5], fn0.str, fn1.str, o0, C1[3] ? o1 : '0));
      cmp_pin(pad_ie, mix(sw[1], fn0.ie, fn1.ie, o0, C1[4] ? o1 : '0));
    end
    end_of_test();
  end
endmodule : tb_gpio_pad_controller
